/* File: verilog/spio_pkg.sv */
// Constants and types of the shared parallel I/O port
`default_nettype none

package spio_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int PADW = 16;
   localparam int AW = 12;

   // ****************************************************************
   // Register indices and byte addresses
   // ****************************************************************
   localparam logic [AW-1:0] IDX_DIR = 12'h2c0;
   localparam logic [AW-1:0] IDX_VAL = 12'h2c2;
   localparam logic [AW-1:0] IDX_LAT = 12'h2c4;
   localparam logic [AW-1:0] IDX_ANA = 12'h2fe;
   localparam logic [AW-1:0] ADDR_DIR = 12'(IDX_DIR * 4);
   localparam logic [AW-1:0] ADDR_VAL = 12'(IDX_VAL * 4);
   localparam logic [AW-1:0] ADDR_LAT = 12'(IDX_LAT * 4);
   localparam logic [AW-1:0] ADDR_ANA = 12'(IDX_ANA * 4);

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [PADW-1:0] DIR_RST = 16'hffff;
   localparam logic [PADW-1:0] LAT_RST = 16'h0000;
   localparam logic [PADW-1:0] ANA_RST = 16'h0000;

   // ****************************************************************
   // Bus responses
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [4:0] {
      SEL_NONE = 5'h01,
      SEL_DIR = 5'h02,
      SEL_VAL = 5'h04,
      SEL_LAT = 5'h08,
      SEL_ANA = 5'h10
   } spio_sel_t;

   typedef enum logic [1:0] {
      W_IDLE = 2'h1,
      W_RESP = 2'h2
   } spio_wst_t;

   typedef enum logic [1:0] {
      R_IDLE = 2'h1,
      R_DATA = 2'h2
   } spio_rst_t;

   typedef struct packed {
      logic [PADW-1:0] en;
      logic [PADW-1:0] drive;
      logic [PADW-1:0] dout;
      logic [PADW-1:0] oe;
   } spio_periph_t;

   typedef struct packed {
      logic [PADW-1:0] dout;
      logic [PADW-1:0] oe;
   } spio_pad_t;

   typedef struct packed {
      logic [PADW-1:0] dir;
      logic [PADW-1:0] lat;
      logic [PADW-1:0] ana;
      logic [PADW-1:0] sync1;
      logic [PADW-1:0] sync2;
      spio_pad_t pad;
      logic [PADW-1:0] adc_level;
      spio_wst_t wst;
      logic aw_full;
      logic [AW-1:0] aw_addr;
      logic w_full;
      logic [PADW-1:0] w_data;
      logic [1:0] w_strb;
      logic awready;
      logic wready;
      logic [1:0] bresp;
      spio_rst_t rst;
      logic [PADW-1:0] rdata;
      logic [1:0] rresp;
   } spio_state_t;

endpackage

`default_nettype wire

/* File: verilog/spio_pad_mux.sv */
// Output ownership multiplexers between peripherals and the port
`timescale 1ns/1ps
`default_nettype none

module spio_pad_mux #(
   parameter logic [spio_pkg::PADW-1:0] IMPL = 16'hffff,
   parameter logic [spio_pkg::PADW-1:0] SHARED = 16'hffff
) (
   // Port settings
   input wire logic [spio_pkg::PADW-1:0] dir,
   input wire logic [spio_pkg::PADW-1:0] lat,
   // Peripheral side
   input wire spio_pkg::spio_periph_t periph,
   // Pad side
   output wire spio_pkg::spio_pad_t pad,
   output wire logic [spio_pkg::PADW-1:0] own
);

   genvar i;
   generate
      for (i = 0; i < spio_pkg::PADW; i = i + 1) begin : g_bit
         if (IMPL[i] && SHARED[i]) begin : g_shared
            // Peripheral wins while enabled and driving
            assign own[i] = periph.en[i] & periph.drive[i];
            assign pad.dout[i] = own[i] ? periph.dout[i]
               : lat[i];
            assign pad.oe[i] = own[i] ? periph.oe[i] : ~dir[i];
         end else if (IMPL[i]) begin : g_dedicated
            // Input-only sharing, port alone drives
            assign own[i] = 1'b0;
            assign pad.dout[i] = lat[i];
            assign pad.oe[i] = ~dir[i];
         end else begin : g_absent
            assign own[i] = 1'b0;
            assign pad.dout[i] = 1'b0;
            assign pad.oe[i] = 1'b0;
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* File: verilog/spio_port.sv */
// Shared parallel I/O port with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Driving peripheral disables the port driver; the pin stays readable.
// - Enabled but idle peripheral leaves the pin to the port's settings.
// - Direction bit one makes the pin input; zero drives the latch out.
// - Reset sets every implemented direction bit, so all pins not driven by a peripheral are inputs.
// - Latch register reads the latch and writes update the latch.
// - Pin value register reads the pins; writes go to the latch.
// - Unimplemented bits hold nothing and read as zero everywhere.
// - Pins shared only with input functions are plain port pins.
// - Shared pins use a mux pair; the peripheral wins data and enable.
// - Analog-configured pins read as zero in the pin value register.
// - Digital-configured pins pass no level to the analog converter.
module spio_port #(
   parameter logic [spio_pkg::PADW-1:0] IMPL = 16'hffff,
   parameter logic [spio_pkg::PADW-1:0] SHARED = 16'hffff,
   parameter logic [spio_pkg::PADW-1:0] ANALOG = 16'hffff
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [spio_pkg::AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [spio_pkg::AW-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Peripherals
   input wire spio_pkg::spio_periph_t periph,
   // Pads
   input wire logic [spio_pkg::PADW-1:0] pad_in,
   output logic [spio_pkg::PADW-1:0] pad_out,
   output logic [spio_pkg::PADW-1:0] pad_oe,
   // Analog converter
   output logic [spio_pkg::PADW-1:0] adc_sel,
   output logic [spio_pkg::PADW-1:0] adc_level
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic spio_pkg::spio_sel_t decode(
      input logic [spio_pkg::AW-1:0] addr
   );
      case (addr)
         spio_pkg::ADDR_DIR: decode = spio_pkg::SEL_DIR;
         spio_pkg::ADDR_VAL: decode = spio_pkg::SEL_VAL;
         spio_pkg::ADDR_LAT: decode = spio_pkg::SEL_LAT;
         spio_pkg::ADDR_ANA: decode = spio_pkg::SEL_ANA;
         default: decode = spio_pkg::SEL_NONE;
      endcase
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   spio_pkg::spio_state_t q;
   spio_pkg::spio_state_t next_q;
   spio_pkg::spio_pad_t mux_pad;
   logic [spio_pkg::PADW-1:0] own;
   logic [spio_pkg::PADW-1:0] pin_read;
   logic [spio_pkg::PADW-1:0] wmask;
   logic [spio_pkg::PADW-1:0] wval;
   spio_pkg::spio_sel_t wsel;
   spio_pkg::spio_sel_t rsel;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;

   // ****************************************************************
   // Pad multiplexers
   // ****************************************************************
   spio_pad_mux #(
      .IMPL(IMPL),
      .SHARED(SHARED)
   ) u_mux (
      .dir(q.dir),
      .lat(q.lat),
      .periph(periph),
      .pad(mux_pad),
      .own(own)
   );

   // Pin levels as software sees them
   assign pin_read = q.sync2 & IMPL & ~(q.ana & ANALOG);
   assign wmask = {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
   assign wsel = decode(q.aw_addr);
   assign rsel = decode(araddr);
   assign aw_take = awvalid & q.awready;
   assign w_take = wvalid & q.wready;
   assign ar_take = arvalid & (q.rst == spio_pkg::R_IDLE);
   assign do_write = q.aw_full & q.w_full & (q.wst == spio_pkg::W_IDLE);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_q = q;
      wval = 16'h0000;
      // Pin synchroniser
      next_q.sync1 = pad_in;
      next_q.sync2 = q.sync1;
      // Registered pad drive
      next_q.pad = mux_pad;
      // Converter only sees analog-configured pins
      next_q.adc_level = q.sync2 & q.ana & ANALOG;
      // Address and data capture, either order
      if (aw_take) begin
         next_q.aw_full = 1'b1;
         next_q.aw_addr = awaddr;
      end
      if (w_take) begin
         next_q.w_full = 1'b1;
         next_q.w_data = wdata[spio_pkg::PADW-1:0];
         next_q.w_strb = wstrb[1:0];
      end
      // Write machine
      case (q.wst)
         spio_pkg::W_IDLE: begin
            if (do_write) begin
               next_q.aw_full = 1'b0;
               next_q.w_full = 1'b0;
               next_q.bresp = spio_pkg::RESP_OKAY;
               next_q.wst = spio_pkg::W_RESP;
               case (wsel)
                  spio_pkg::SEL_DIR: begin
                     wval = (q.dir & ~wmask) | (q.w_data & wmask);
                     next_q.dir = wval & IMPL;
                  end
                  spio_pkg::SEL_VAL, spio_pkg::SEL_LAT: begin
                     wval = (q.lat & ~wmask) | (q.w_data & wmask);
                     next_q.lat = wval & IMPL;
                  end
                  spio_pkg::SEL_ANA: begin
                     wval = (q.ana & ~wmask) | (q.w_data & wmask);
                     next_q.ana = wval & ANALOG & IMPL;
                  end
                  default: begin
                     next_q.bresp = spio_pkg::RESP_SLVERR;
                  end
               endcase
            end
         end
         spio_pkg::W_RESP: begin
            if (bready) begin
               next_q.wst = spio_pkg::W_IDLE;
            end
         end
         default: begin
            next_q.wst = spio_pkg::W_IDLE;
         end
      endcase
      next_q.awready = ~next_q.aw_full & (next_q.wst == spio_pkg::W_IDLE);
      next_q.wready = ~next_q.w_full & (next_q.wst == spio_pkg::W_IDLE);
      // Read machine
      case (q.rst)
         spio_pkg::R_IDLE: begin
            if (ar_take) begin
               next_q.rst = spio_pkg::R_DATA;
               next_q.rresp = spio_pkg::RESP_OKAY;
               case (rsel)
                  spio_pkg::SEL_DIR: next_q.rdata = q.dir;
                  spio_pkg::SEL_VAL: next_q.rdata = pin_read;
                  spio_pkg::SEL_LAT: next_q.rdata = q.lat;
                  spio_pkg::SEL_ANA: next_q.rdata = q.ana;
                  default: begin
                     next_q.rdata = 16'h0000;
                     next_q.rresp = spio_pkg::RESP_SLVERR;
                  end
               endcase
            end
         end
         spio_pkg::R_DATA: begin
            if (rready) begin
               next_q.rst = spio_pkg::R_IDLE;
            end
         end
         default: begin
            next_q.rst = spio_pkg::R_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q.dir <= spio_pkg::DIR_RST & IMPL;
         q.lat <= spio_pkg::LAT_RST;
         q.ana <= spio_pkg::ANA_RST;
         q.sync1 <= 16'h0000;
         q.sync2 <= 16'h0000;
         q.pad <= '0;
         q.adc_level <= 16'h0000;
         q.wst <= spio_pkg::W_IDLE;
         q.aw_full <= 1'b0;
         q.aw_addr <= 12'h000;
         q.w_full <= 1'b0;
         q.w_data <= 16'h0000;
         q.w_strb <= 2'h0;
         q.awready <= 1'b0;
         q.wready <= 1'b0;
         q.bresp <= spio_pkg::RESP_OKAY;
         q.rst <= spio_pkg::R_IDLE;
         q.rdata <= 16'h0000;
         q.rresp <= spio_pkg::RESP_OKAY;
      end else begin
         q <= next_q;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = (q.wst == spio_pkg::W_RESP);
   assign bresp = q.bresp;
   assign arready = (q.rst == spio_pkg::R_IDLE);
   assign rvalid = (q.rst == spio_pkg::R_DATA);
   assign rdata = {16'h0000, q.rdata};
   assign rresp = q.rresp;
   assign pad_out = q.pad.dout;
   assign pad_oe = q.pad.oe;
   assign adc_sel = q.ana;
   assign adc_level = q.adc_level;

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_PERIPH_OWNS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      aresetn && (|(own & ~periph.oe)) |=>
         (pad_oe & $past(own)) == $past(own & periph.oe)
   ) else $error("Peripheral does not own the pad enable");

   AST_IDLE_PERIPH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (|(periph.en & ~periph.drive & IMPL)) |=>
         ((pad_oe ^ ~$past(q.dir))
            & $past(periph.en & ~periph.drive & IMPL)) == 16'h0000
   ) else $error("Idle peripheral blocks the port");

   AST_OUT_FROM_LAT: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ##1 ((pad_out ^ $past(q.lat)) & $past(~own & ~q.dir & IMPL)) == 16'h0000
   ) else $error("Output pin does not follow the latch");

   AST_RESET_INPUT: assert property (
      @(posedge aclk)
      !aresetn |=> (q.dir == IMPL) ##1 ((pad_oe & ~$past(own)) == 16'h0000)
   ) else $error("Pins are not inputs after reset");

   AST_LAT_READ: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_take && (rsel == spio_pkg::SEL_LAT) |=>
         rvalid && (rdata[15:0] == $past(q.lat))
   ) else $error("Latch read returned other data");

   AST_VAL_WRITE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && (wsel == spio_pkg::SEL_VAL) && (q.w_strb == 2'h3) |=>
         (q.lat == ($past(q.w_data) & IMPL)) ##1 bvalid || $past(bready)
   ) else $error("Pin value write missed the latch");

   AST_UNIMPL_ZERO: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rvalid |-> ((rdata[15:0] & ~IMPL) == 16'h0000)
         && (rdata[31:16] == 16'h0000)
   ) else $error("Unimplemented bit read as one");

   AST_DEDICATED: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ##1 ((pad_oe ^ ~$past(q.dir)) & IMPL & ~SHARED) == 16'h0000
   ) else $error("Dedicated pin taken by a peripheral");

   AST_PERIPH_DATA: assert property (
      @(posedge aclk) disable iff (!aresetn)
      aresetn && (|own) |=>
         ((pad_out ^ $past(periph.dout)) & $past(own)) == 16'h0000
   ) else $error("Peripheral data lost at the pad");

   AST_ANALOG_ZERO: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_take && (rsel == spio_pkg::SEL_VAL) |=>
         (rdata[15:0] & $past(q.ana)) == 16'h0000
   ) else $error("Analog pin read nonzero");

   AST_ADC_BLOCK: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ##1 (adc_level & ~$past(q.ana)) == 16'h0000
   ) else $error("Digital pin reached the converter");

   AST_PORT_ENABLE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $stable(q.dir) && (own == 16'h0000) |=>
         (pad_oe == (~$past(q.dir) & IMPL))
   ) else $error("Port enable is not inverse direction");

   AST_DIR_WRITE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && (wsel == spio_pkg::SEL_DIR) && (q.w_strb == 2'h3) |=>
         q.dir == ($past(q.w_data) & IMPL)
   ) else $error("Direction write did not land");

   AST_LAT_WRITE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      do_write && (wsel == spio_pkg::SEL_LAT) && (q.w_strb == 2'h3) |=>
         q.lat == ($past(q.w_data) & IMPL)
   ) else $error("Latch write did not land");

   AST_UNIMPL_PAD: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ((pad_oe | pad_out) & ~IMPL) == 16'h0000
   ) else $error("Unimplemented pin driven");

   AST_BRESP_TIME: assert property (
      @(posedge aclk) disable iff (!aresetn)
      aw_take && w_take |-> ##[1:2] bvalid
   ) else $error("Write response late");

endmodule

`default_nettype wire

/* File: sim/spio_pins.sv */
// Pin-side model: pads meeting external board levels
`timescale 1ns/1ps
`default_nettype none

module spio_pins (
   // Pad drive from the port
   input wire logic [15:0] pad_out,
   input wire logic [15:0] pad_oe,
   // Board levels on undriven pins
   input wire logic [15:0] ext,
   // Levels seen at the pins
   output logic [15:0] pad_in
);
   // Driven pins show the pad data, the rest the board level
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking testbench of the shared parallel I/O port
`timescale 1ns/1ps
`default_nettype none

module testbench;
   // ****
   // Stimulus and model state
   // ****
   localparam logic [15:0] IM = 16'h7fff;
   localparam logic [15:0] SH = 16'h00ff;
   localparam logic [15:0] AN = 16'h000f;
   localparam logic [1:0] OK = spio_pkg::RESP_OKAY;
   localparam logic [1:0] ER = spio_pkg::RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hf, s;
   logic [15:0] k;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   spio_pkg::spio_periph_t periph = '0;
   logic [15:0] pad_in, pad_out, pad_oe, adc_sel, adc_level;
   logic [15:0] ext = 16'h0000;
   logic [15:0] m_dir = IM, m_lat = 16'h0000, m_ana = 16'h0000;
   logic [15:0] own, e_oe, e_out, e_pin;
   logic [17:0] rq[$];
   logic [1:0] bq[$];
   int n_fail = 0;
   int check_count = 0;
   int seed = 13;
   logic [31:0] v;

   always #4 aclk = ~aclk;

   spio_port #(.IMPL(IM), .SHARED(SH), .ANALOG(AN)) i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .periph(periph), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .adc_sel(adc_sel), .adc_level(adc_level)
   );

   spio_pins i_pins (
      .pad_out(pad_out), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in)
   );

   // Expected pad ownership and pin levels
   always_comb begin
      own = periph.en & periph.drive & SH & IM;
      e_oe = (own & periph.oe) | (~own & ~m_dir & IM);
      e_out = (own & periph.dout) | (~own & m_lat);
      e_pin = (e_oe & e_out) | (~e_oe & ext);
   end

   // ****
   // Checks and bus tasks
   // ****
   task automatic bad(input string m);
      n_fail++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      check_count++;
      if (got !== exp) begin
         bad("write response");
      end
   endtask

   task automatic cmp_read(input logic [31:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== {16'h0000, exp[15:0]} || rresp !== exp[17:16]) begin
         bad("read data or response");
      end
   endtask

   task automatic cmp_pad();
      check_count++;
      if ((pad_oe & IM) !== e_oe || (pad_out & e_oe) !== (e_out & e_oe)
          || adc_sel !== m_ana || adc_level !== (e_pin & m_ana)) begin
         bad("pad or converter outputs");
      end
   endtask

   // Results are matched against the oldest note
   always @(posedge aclk) begin
      if (bvalid && bready) begin
         cmp_resp(bresp, bq.pop_front());
      end
      if (rvalid && rready) begin
         cmp_read(rdata, rq.pop_front());
      end
   end

   task automatic wr(input logic [11:0] a, input logic [15:0] d,
                     input logic [3:0] st, input logic [1:0] r);
      logic done;
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] d,
                     input logic [1:0] r);
      logic done;
      rq.push_back({r, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ****
   // Main sequence
   // ****
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      end_of_test();
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(spio_pkg::ADDR_DIR, IM, OK);
      rd(spio_pkg::ADDR_LAT, 16'h0000, OK);
      rd(spio_pkg::ADDR_ANA, 16'h0000, OK);
      cmp_pad();
      for (int i = 0; i < 8; i++) begin
         if (i == 4) begin
            m_ana = 16'h0035 & AN;
            wr(spio_pkg::ADDR_ANA, 16'h0035, 4'hf, OK);
            rd(spio_pkg::ADDR_ANA, m_ana, OK);
         end
         v = $random(seed);
         s = (i > 5) ? 4'($random(seed)) : 4'hf;
         k = {{8{s[1]}}, {8{s[0]}}};
         m_lat = ((m_lat & ~k) | (v[15:0] & k)) & IM;
         if (i[0]) begin
            wr(spio_pkg::ADDR_VAL, v[15:0], s, OK);
         end else begin
            wr(spio_pkg::ADDR_LAT, v[15:0], s, OK);
         end
         v = $random(seed);
         m_dir = (v[15:0] | m_ana) & IM;
         wr(spio_pkg::ADDR_DIR, v[15:0] | m_ana, 4'hf, OK);
         ext <= 16'($random(seed));
         periph <= {$random(seed), $random(seed)};
         repeat (6) @(posedge aclk);
         cmp_pad();
         rd(spio_pkg::ADDR_LAT, m_lat, OK);
         rd(spio_pkg::ADDR_VAL, e_pin & IM & ~m_ana, OK);
         rd(spio_pkg::ADDR_DIR, m_dir, OK);
      end
      wr(12'h004, 16'h1234, 4'hf, ER);
      rd(12'h004, 16'h0000, ER);
      rd(spio_pkg::ADDR_LAT, m_lat, OK);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      m_dir = IM;
      m_lat = 16'h0000;
      m_ana = 16'h0000;
      repeat (2) @(posedge aclk);
      rd(spio_pkg::ADDR_DIR, IM, OK);
      repeat (3) @(posedge aclk);
      cmp_pad();
      end_of_test();
   end
endmodule
`default_nettype wire
